// [bench/tcr_pin_model.sv]
// Purpose: port A pins and capture source seen from the board
// Assumes: released pins are pulled up on the board
// Notes:   one capture pulse per request, long enough to be synchronised
`timescale 1ns/100ps
`default_nettype none
module tcr_pin_model (
  input  wire logic       clk,
  input  wire logic [4:0] pa_out,
  input  wire logic [4:0] pa_drive,
  input  wire logic       edge_req,
  output var  logic [3:0] cap_in,
  output var  logic [4:0] pin_level
);
  logic [2:0] hold_reg = 3'h0;  // cycles left on the capture pulse
  // a pin the timer does not drive floats up to the pull-up level
  assign pin_level = (pa_out & pa_drive) | ~pa_drive;
  // capture one stays high six cycles so the edge detector cannot miss it
  always_ff @(posedge clk) begin
    if (edge_req) begin
      hold_reg <= 3'h6;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign cap_in = {3'h0, hold_reg != 3'h0};
endmodule // tcr_pin_model
`default_nettype wire

// [bench/timer_compare_rti_unit_tb.sv]
// Purpose: self-checking bench of the timer compare and periodic unit
// Assumes: periodic base shortened to 16 cycles
// Notes:   prescale is locked to divide by one, so the count steps each cycle
`timescale 1ns/100ps
`default_nettype none
module timer_compare_rti_unit_tb;
  localparam int RL = 4;          // shortened periodic base exponent
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic [3:0]  cap_in;
  logic [4:0]  pa_out;
  logic [4:0]  pa_drive;
  logic [4:0]  pin_level;
  logic        irq;
  logic        cap_pulse = 1'b0;
  logic [31:0] q;                 // last read value
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;           // free cycle count for interval checks
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tcr_timer_unit #(.RTI_LOG2(RL)) dut (
    .CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .CAP_IN(cap_in),
    .PA_OUT(pa_out), .PA_DRIVE(pa_drive), .TIMER_IRQ(irq));
  tcr_pin_model pins (.clk(clk), .pa_out(pa_out), .pa_drive(pa_drive),
    .edge_req(cap_pulse), .cap_in(cap_in), .pin_level(pin_level));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (n >= 20) check("bus answer", 32'h1, 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd8(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // reset values and unimplemented bits; prescale locked at divide by one
  task automatic t_reset();
    wr8(tcr_pkg::OFF_MASK2, 8'h0C);
    rd8(tcr_pkg::OFF_MASK2);
    check("mask2", q, 32'h0);
    rd8(tcr_pkg::OFF_CMP_BASE);
    check("cmp hi", q, 32'hFF);
    wr8(tcr_pkg::OFF_DATA1P, 8'hFF);
    rd8(tcr_pkg::OFF_DATA1P);
    check("data1", q, 32'hF8);
    rd8(8'hFC);
    check("unmapped", q, 32'h0);
  endtask
  // forced compares on channel three through every mode pair
  task automatic t_force_modes();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(3 - i);
      wr8(tcr_pkg::OFF_PINCTL, {2'b00, m, 4'h0});
      // the pin action is forced with no compare match anywhere near the count
      wr8(tcr_pkg::OFF_FORCE, 8'h20);
      repeat (4) @(posedge clk);
      check("drive ch3", pa_drive[2], m != 2'b00);
      check("pin ch3", pin_level[2], i != 1);
    end
    rd8(tcr_pkg::OFF_CHFLAG);
    check("forced flag", q[5], 1'b0);
    rd8(tcr_pkg::OFF_FORCE);
    check("force reads", q, 32'h0);
  endtask
  // channel five obeys the shared select
  task automatic t_shared();
    wr8(tcr_pkg::OFF_ACCCTL, 8'h04);
    wr8(tcr_pkg::OFF_PINCTL, 8'h03);
    wr8(tcr_pkg::OFF_FORCE, 8'h08);
    repeat (4) @(posedge clk);
    check("ch5 off", pa_out[0], 1'b0);
    wr8(tcr_pkg::OFF_ACCCTL, 8'h00);
    wr8(tcr_pkg::OFF_FORCE, 8'h08);
    repeat (4) @(posedge clk);
    check("ch5 on", pa_out[0], 1'b1);
  endtask
  // real match of channel one drives only masked pins
  task automatic t_multi();
    logic [15:0] c;
    wr8(tcr_pkg::OFF_MASK1P, 8'hF0);
    wr8(tcr_pkg::OFF_DATA1P, 8'h50);
    rd8(tcr_pkg::OFF_CNT_HI);
    c[15:8] = q[7:0];
    rd8(tcr_pkg::OFF_CNT_LO);
    c = {c[15:8], q[7:0]} + 16'h0040;
    wr8(tcr_pkg::OFF_CMP_BASE, c[15:8]);
    wr8(tcr_pkg::OFF_CMP_BASE + tcr_pkg::CMP_LO_STEP, c[7:0]);
    repeat (80) @(posedge clk);
    check("ch1 pins", pa_out, 5'b01011);
    rd8(tcr_pkg::OFF_CHFLAG);
    check("ch1 flag", q[7], 1'b1);
    wr8(tcr_pkg::OFF_CHFLAG, 8'h00);
    rd8(tcr_pkg::OFF_CHFLAG);
    check("zero write", q[7], 1'b1);
    wr8(tcr_pkg::OFF_CHFLAG, 8'h80);
    rd8(tcr_pkg::OFF_CHFLAG);
    check("cleared", q[7], 1'b0);
  endtask
  // latched lower byte lags a live read two accesses later by six cycles, twice the bus spacing
  task automatic t_count();
    logic [7:0] a;
    rd8(tcr_pkg::OFF_CNT_HI);
    rd8(tcr_pkg::OFF_CNT_LO);
    a = q[7:0];
    rd8(tcr_pkg::OFF_CNT_LO);
    check("count latch", 8'(q[7:0] - a), 8'h06);
  endtask
  // capture edge sets its flag, mask turns it into a request
  task automatic t_capture();
    @(posedge clk);
    cap_pulse <= 1'b1;
    @(posedge clk);
    cap_pulse <= 1'b0;
    repeat (10) @(posedge clk);
    rd8(tcr_pkg::OFF_CHFLAG);
    check("cap flag", q[2], 1'b1);
    wr8(tcr_pkg::OFF_CHMASK, 8'h04);
    repeat (2) @(posedge clk);
    check("cap irq", irq, 1'b1);
    wr8(tcr_pkg::OFF_CHFLAG, 8'h04);
    repeat (2) @(posedge clk);
    check("cap irq off", irq, 1'b0);
    wr8(tcr_pkg::OFF_CHMASK, 8'h00);
  endtask
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) check("irq wait", 32'h1, 32'h0);
    t = cyc;
  endtask
  // periodic interval for every rate code, measured timeout to timeout
  task automatic t_periodic();
    int t0;
    int t1;
    // a late prescale write is ignored; only the enable bits land
    wr8(tcr_pkg::OFF_MASK2, 8'h43);
    rd8(tcr_pkg::OFF_MASK2);
    check("late prescale", q, 32'h40);
    for (int r = 0; r < 4; r++) begin
      wr8(tcr_pkg::OFF_ACCCTL, 8'(r));
      // two clears: the first may meet a timeout and lose to it
      repeat (2) begin
        wait_irq(t0);
        wr8(tcr_pkg::OFF_FLAG2, 8'h40);
      end
      wait_irq(t0);
      rd8(tcr_pkg::OFF_FLAG2);
      check("flag2", q, 32'h40);
      wr8(tcr_pkg::OFF_FLAG2, 8'h40);
      wait_irq(t1);
      check("period", t1 - t0, 16 << r);
    end
    wr8(tcr_pkg::OFF_MASK2, 8'h00);
  endtask
  // counter wrap sets the wrap flag and, when enabled, the request
  task automatic t_wrap();
    int n;
    n = 0;
    wr8(tcr_pkg::OFF_MASK2, 8'h80);
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    check("wrap irq", irq, 1'b1);
    rd8(tcr_pkg::OFF_FLAG2);
    check("wrap flag", q[7], 1'b1);
    wr8(tcr_pkg::OFF_FLAG2, 8'h80);
    @(posedge clk);
    check("wrap irq off", irq, 1'b0);
    wr8(tcr_pkg::OFF_MASK2, 8'h00);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_force_modes();
    t_shared();
    t_multi();
    t_count();
    t_capture();
    t_periodic();
    t_wrap();
    complete_run();
  end
  // hang guard, beyond the wrap wait of some 66000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule // timer_compare_rti_unit_tb
`default_nettype wire

// [rtl/tcr_cmp_chan.sv]
// Purpose: one 16-bit compare register with its comparator
// Assumes: write strobes are one-cycle pulses at the bus completion edge
// Notes:   match is a one-cycle pulse, one cycle after the count step
`timescale 1ns/100ps
`default_nettype none
module tcr_cmp_chan (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wdata,
  input  wire logic [15:0] count,
  input  wire logic        cnt_step,
  output var  logic [15:0] cmp_val,
  output var  logic        match
);
  // all state of the channel
  typedef struct packed {
    logic [15:0] cmp;    // compare value
    logic        inhib;  // upper-byte write blanking
    logic        match;  // match pulse
  } tcr_chan_t;
  tcr_chan_t s_reg;
  tcr_chan_t s_next;

  // next state: byte writes, blanking and equality test
  always_comb begin
    s_next = s_reg;
    if (wr_hi) begin
      s_next.cmp[15:8] = wdata;
    end
    if (wr_lo) begin
      s_next.cmp[7:0] = wdata;
    end
    s_next.inhib = wr_hi;
    s_next.match = cnt_step && !wr_hi && !s_reg.inhib
                   && (count == s_reg.cmp);
  end

  // register the state; compare value starts at all ones
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg.cmp   <= tcr_pkg::CMP_RESET;
      s_reg.inhib <= 1'b0;
      s_reg.match <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmp_val = s_reg.cmp;
  assign match   = s_reg.match;

  chk_inhibit_after_write: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_hi |=> !match ##1 !match) else $error("match during blanking");
endmodule // tcr_cmp_chan
`default_nettype wire

// [rtl/tcr_pkg.sv]
// Purpose: shared constants of the timer compare and periodic unit
// Assumes: one 32-bit word per register, data in byte lane 0
// Notes:   compare pair k sits at OFF_CMP_BASE + k*CMP_STRIDE (upper byte)
`default_nettype none
package tcr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_FORCE    = 8'h00;
  localparam logic [7:0] OFF_MASK1P   = 8'h04;
  localparam logic [7:0] OFF_DATA1P   = 8'h08;
  localparam logic [7:0] OFF_CNT_HI   = 8'h0C;
  localparam logic [7:0] OFF_CNT_LO   = 8'h10;
  localparam logic [7:0] OFF_PINCTL   = 8'h14;
  localparam logic [7:0] OFF_CHMASK   = 8'h18;
  localparam logic [7:0] OFF_CHFLAG   = 8'h1C;
  localparam logic [7:0] OFF_MASK2    = 8'h20;
  localparam logic [7:0] OFF_FLAG2    = 8'h24;
  localparam logic [7:0] OFF_ACCCTL   = 8'h28;
  localparam logic [7:0] OFF_CMP_BASE = 8'h2C;
  localparam logic [7:0] CMP_STRIDE   = 8'h08;
  localparam logic [7:0] CMP_LO_STEP  = 8'h04;
  // implemented bit masks (others read zero)
  localparam logic [7:0] MASK_HI5     = 8'hF8;
  localparam logic [7:0] MASK_HI4     = 8'hF0;
  localparam logic [7:0] MASK_MASK2   = 8'hF3;
  localparam logic [7:0] MASK_ACCCTL  = 8'h07;
  // field positions
  localparam int         BIT_WRAP     = 7;
  localparam int         BIT_PERIODIC = 6;
  localparam int         BIT_SHARED   = 3;
  localparam int         BIT_SELECT   = 2;
  localparam int         NUM_CMP      = 5;
  // reset values
  localparam logic [15:0] CMP_RESET   = 16'hFFFF;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  // timing counts in clock cycles
  localparam logic [6:0]  PR_WINDOW_CYCLES = 7'h40;
  localparam int          RTI_BASE_LOG2    = 13;
  // prescale masks for codes 00..11 : divide by 1, 4, 8, 16
  localparam logic [3:0]  PRE_DIV1  = 4'h0;
  localparam logic [3:0]  PRE_DIV4  = 4'h3;
  localparam logic [3:0]  PRE_DIV8  = 4'h7;
  localparam logic [3:0]  PRE_DIV16 = 4'hF;
endpackage
`default_nettype wire

// [rtl/tcr_timer_unit.sv]
// Purpose: compare pin actions, coherent count read, prescaler, flags,
//          masks and the periodic interrupt of the timer unit
// Assumes: Avalon-MM slave, one aligned word per 8-bit register
// Notes:   one access completes two edges after it is raised
`timescale 1ns/100ps
`default_nettype none
module tcr_timer_unit #(
  parameter int RTI_LOG2 = tcr_pkg::RTI_BASE_LOG2  // shorten for simulation
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  input  wire logic [3:0]  CAP_IN,
  output var  logic [4:0]  PA_OUT,
  output var  logic [4:0]  PA_DRIVE,
  output var  logic        TIMER_IRQ
);
  // all state of the unit
  typedef struct packed {
    logic [15:0] count;      // free_running_counter
    logic        step;       // count changed on the last edge
    logic [3:0]  presc;      // prescale divider
    logic [15:0] rti;        // periodic divider
    logic [7:0]  lo_buf;     // latched lower count byte
    logic        buf_ok;     // lo_buf valid for the next access
    logic [4:0]  force_pend; // forced actions waiting for a step
    logic [7:0]  mask1p;     // multi_pin_mask_reg
    logic [7:0]  data1p;     // multi_pin_data_reg
    logic [7:0]  pinctl;     // pin_action_control_reg
    logic [7:0]  chmask;     // channel_mask_reg
    logic [7:0]  chflag;     // channel_flag_reg
    logic [7:0]  mask2;      // second_mask_reg
    logic [7:0]  flag2;      // second_flag_reg
    logic [7:0]  accctl;     // shared select and periodic rate
    logic        pr_lock;    // prescale already written
    logic [6:0]  win;        // cycles since reset, saturating
    logic [3:0]  cs1;        // capture sync stage one
    logic [3:0]  cs2;        // capture sync stage two
    logic [3:0]  cs3;        // capture sync stage three
    logic [3:0]  cap_q;      // agreed capture level
    logic [4:0]  pa;         // pins 7..3
    logic [4:0]  drive;      // pins 7..3 owned by the timer
    logic        irq;        // interrupt request
    logic        wait_n;     // low while answering
    logic [31:0] rdata;      // read answer
  } tcr_state_t;
  tcr_state_t s_reg;
  tcr_state_t s_next;

  // compare channel wires
  logic [15:0] cmp_val [tcr_pkg::NUM_CMP];
  logic [4:0]  cmp_match;        // index 0 = channel one
  logic [4:0]  cmp_wr_hi;
  logic [4:0]  cmp_wr_lo;
  logic        acc;              // access completes on this edge
  logic        wr_ok;            // completing write to lane 0
  logic [7:0]  wd;               // write byte
  logic [7:0]  rd_byte;          // read value of the addressed register

  // address of a compare pair byte; used for decode and for read mux
  function automatic logic [7:0] cmp_addr(input int ch, input logic hi);
    logic [7:0] a;
    a = tcr_pkg::OFF_CMP_BASE + 8'(ch) * tcr_pkg::CMP_STRIDE;
    return hi ? a : a + tcr_pkg::CMP_LO_STEP;
  endfunction

  // low-bit mask of a periodic interval 2^(RTI_LOG2+rate)
  function automatic logic [15:0] rti_mask(input logic [1:0] rate);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 16; i++) begin
      if (i < RTI_LOG2 + int'(rate)) m[i] = 1'b1;
    end
    return m;
  endfunction

  // an access completes when the request meets a low waitrequest
  assign acc   = (AVS_READ || AVS_WRITE) && !s_reg.wait_n;
  assign wr_ok = acc && AVS_WRITE && AVS_BYTEENABLE[0];
  assign wd    = AVS_WRITEDATA[7:0];

  // five compare channels
  genvar g;
  generate
    for (g = 0; g < tcr_pkg::NUM_CMP; g++) begin : g_cmp
      assign cmp_wr_hi[g] = wr_ok && (AVS_ADDRESS == cmp_addr(g, 1'b1));
      assign cmp_wr_lo[g] = wr_ok && (AVS_ADDRESS == cmp_addr(g, 1'b0));
      tcr_cmp_chan u_chan (
        .clk      (CLK),
        .rstn     (RESETN),
        .wr_hi    (cmp_wr_hi[g]),
        .wr_lo    (cmp_wr_lo[g]),
        .wdata    (wd),
        .count    (s_reg.count),
        .cnt_step (s_reg.step),
        .cmp_val  (cmp_val[g]),
        .match    (cmp_match[g])
      );
    end
  endgenerate

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    case (AVS_ADDRESS)
      tcr_pkg::OFF_FORCE:  rd_byte = 8'h00;
      tcr_pkg::OFF_MASK1P: rd_byte = s_reg.mask1p & tcr_pkg::MASK_HI5;
      tcr_pkg::OFF_DATA1P: rd_byte = s_reg.data1p & tcr_pkg::MASK_HI5;
      tcr_pkg::OFF_CNT_HI: rd_byte = s_reg.count[15:8];
      tcr_pkg::OFF_CNT_LO: rd_byte = s_reg.buf_ok ? s_reg.lo_buf
                                                  : s_reg.count[7:0];
      tcr_pkg::OFF_PINCTL: rd_byte = s_reg.pinctl;
      tcr_pkg::OFF_CHMASK: rd_byte = s_reg.chmask;
      tcr_pkg::OFF_CHFLAG: rd_byte = s_reg.chflag;
      tcr_pkg::OFF_MASK2:  rd_byte = s_reg.mask2 & tcr_pkg::MASK_MASK2;
      tcr_pkg::OFF_FLAG2:  rd_byte = s_reg.flag2 & tcr_pkg::MASK_HI4;
      tcr_pkg::OFF_ACCCTL: rd_byte = s_reg.accctl & tcr_pkg::MASK_ACCCTL;
      default: begin
        for (int k = 0; k < tcr_pkg::NUM_CMP; k++) begin
          if (AVS_ADDRESS == cmp_addr(k, 1'b1)) rd_byte = cmp_val[k][15:8];
          if (AVS_ADDRESS == cmp_addr(k, 1'b0)) rd_byte = cmp_val[k][7:0];
        end
      end
    endcase
  end

  // next-state logic of the whole unit
  always_comb begin
    logic [3:0]  div_mask;   // prescale mask from the select code
    logic        tick;       // counter advances on this edge
    logic        sel_cap;    // shared channel serves capture four
    logic [4:0]  act;        // channels acting on pins this step
    logic [3:0]  cap_edge;   // agreed rising capture edges
    logic [7:0]  ch_set;     // hardware sets of channel flags
    logic [7:0]  f2_set;     // hardware sets of second flags
    logic [7:0]  ch_clr;     // written ones, channel flags
    logic [7:0]  f2_clr;     // written ones, second flags
    logic [1:0]  mode;       // pin action pair
    div_mask = tcr_pkg::PRE_DIV1;
    tick     = 1'b0;
    sel_cap  = 1'b0;
    act      = '0;
    cap_edge = '0;
    ch_set   = '0;
    f2_set   = '0;
    ch_clr   = '0;
    f2_clr   = '0;
    mode     = 2'b00;
    s_next   = s_reg;

    case (s_reg.mask2[1:0])
      2'b00:   div_mask = tcr_pkg::PRE_DIV1;
      2'b01:   div_mask = tcr_pkg::PRE_DIV4;
      2'b10:   div_mask = tcr_pkg::PRE_DIV8;
      default: div_mask = tcr_pkg::PRE_DIV16;
    endcase
    tick          = ((s_reg.presc & div_mask) == div_mask);
    s_next.presc  = tick ? 4'h0 : s_reg.presc + 4'h1;
    s_next.count  = tick ? s_reg.count + 16'h0001 : s_reg.count;
    s_next.step   = tick;
    sel_cap       = s_reg.accctl[tcr_pkg::BIT_SELECT];

    f2_set[tcr_pkg::BIT_WRAP] = tick && (s_reg.count == tcr_pkg::CNT_TOP);

    s_next.rti = s_reg.rti + 16'h0001;
    f2_set[tcr_pkg::BIT_PERIODIC] =
      ((s_reg.rti & rti_mask(s_reg.accctl[1:0])) ==
       rti_mask(s_reg.accctl[1:0]));

    // capture pins: a change counts once stages two and three agree
    s_next.cs1 = CAP_IN;
    s_next.cs2 = s_reg.cs1;
    s_next.cs3 = s_reg.cs2;
    for (int i = 0; i < 4; i++) begin
      if (s_reg.cs2[i] == s_reg.cs3[i]) begin
        s_next.cap_q[i] = s_reg.cs3[i];
        cap_edge[i]     = s_reg.cs3[i] && !s_reg.cap_q[i];
      end
    end

    // flag sources; compare one and capture one sit highest
    for (int k = 0; k < 4; k++) ch_set[7-k] = cmp_match[k];
    ch_set[tcr_pkg::BIT_SHARED] = sel_cap ? cap_edge[3] : cmp_match[4];
    for (int k = 0; k < 3; k++) ch_set[2-k] = cap_edge[k];

    // act on match or pending force; gate channel five
    act = cmp_match | (tick ? s_reg.force_pend : 5'h00);
    if (sel_cap) act[4] = 1'b0;
    // pending force lasts until the step
    if (tick) s_next.force_pend = '0;

    // channels two to five drive pins 6..3
    for (int c = 1; c < tcr_pkg::NUM_CMP; c++) begin
      mode = s_reg.pinctl[2*(4-c) +: 2];
      if (act[c]) begin
        case (mode)
          2'b01:   s_next.pa[4-c] = !s_next.pa[4-c];
          2'b10:   s_next.pa[4-c] = 1'b0;
          2'b11:   s_next.pa[4-c] = 1'b1;
          default: s_next.pa[4-c] = s_next.pa[4-c];
        endcase
      end
      s_next.drive[4-c] = (mode != 2'b00) && !(c == 4 && sel_cap);
    end
    s_next.drive[4] = 1'b0;
    // channel one last, so its data wins a tie
    for (int p = 0; p < 5; p++) begin
      if (act[0] && s_reg.mask1p[p+3]) s_next.pa[p] = s_reg.data1p[p+3];
      if (s_reg.mask1p[p+3]) s_next.drive[p] = 1'b1;
    end

    // prescale window counter saturates at the limit
    if (s_reg.win != tcr_pkg::PR_WINDOW_CYCLES) begin
      s_next.win = s_reg.win + 7'h01;
    end

    // bus answer: first edge builds the answer, second completes
    s_next.wait_n = 1'b1;
    if ((AVS_READ || AVS_WRITE) && s_reg.wait_n) begin
      s_next.wait_n = 1'b0;
      s_next.rdata  = {24'h000000, rd_byte};
      // latch lower byte from the snapshot that gave the upper byte
      // so a count step before completion cannot tear the pair
      if (AVS_READ && (AVS_ADDRESS == tcr_pkg::OFF_CNT_HI)) begin
        s_next.lo_buf = s_reg.count[7:0];
      end
    end
    if (acc) begin
      // latch serves only the very next access
      s_next.buf_ok = AVS_READ && (AVS_ADDRESS == tcr_pkg::OFF_CNT_HI);
    end
    if (wr_ok) begin
      case (AVS_ADDRESS)
        // force bit 7 is channel one, bit 3 channel five
        tcr_pkg::OFF_FORCE: begin
          for (int k = 0; k < 5; k++) if (wd[7-k]) s_next.force_pend[k] = 1'b1;
        end
        tcr_pkg::OFF_MASK1P: s_next.mask1p = wd & tcr_pkg::MASK_HI5;
        tcr_pkg::OFF_DATA1P: s_next.data1p = wd & tcr_pkg::MASK_HI5;
        tcr_pkg::OFF_PINCTL: s_next.pinctl = wd;
        tcr_pkg::OFF_CHMASK: s_next.chmask = wd;
        tcr_pkg::OFF_CHFLAG: ch_clr = wd;
        tcr_pkg::OFF_FLAG2:  f2_clr = wd & tcr_pkg::MASK_HI4;
        tcr_pkg::OFF_ACCCTL: s_next.accctl = wd & tcr_pkg::MASK_ACCCTL;
        tcr_pkg::OFF_MASK2: begin
          s_next.mask2[7:4] = wd[7:4];
          if (!s_reg.pr_lock && s_reg.win != tcr_pkg::PR_WINDOW_CYCLES) begin
            s_next.mask2[1:0] = wd[1:0];
            s_next.pr_lock    = 1'b1;
          end
        end
        default: s_next.pr_lock = s_reg.pr_lock;
      endcase
    end

    s_next.chflag = (s_reg.chflag & ~ch_clr) | ch_set;
    s_next.flag2  = ((s_reg.flag2 & ~f2_clr) | f2_set) & tcr_pkg::MASK_HI4;

    s_next.irq = |(s_next.chmask & s_next.chflag) ||
                 |(s_next.mask2[7:4] & s_next.flag2[7:4]);
  end

  // state register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_reg        <= '0;
      s_reg.count  <= tcr_pkg::CNT_RESET;
      s_reg.mask1p <= tcr_pkg::REG_RESET;
      s_reg.wait_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA    = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.wait_n;
  assign PA_OUT          = s_reg.pa;
  assign PA_DRIVE        = s_reg.drive;
  assign TIMER_IRQ       = s_reg.irq;

  // checks
  chk_force_read_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == tcr_pkg::OFF_FORCE)
    |-> AVS_READDATA == 32'h0) else $error("force reads nonzero");
  chk_reserved_bits: assert property (@(posedge CLK) disable iff (!RESETN)
    (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == tcr_pkg::OFF_FLAG2)
    |-> AVS_READDATA[3:0] == 4'h0) else $error("reserved bits set");
  chk_wrap_sets_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    (s_reg.step && s_reg.count == 16'h0000) |-> s_reg.flag2[7])
    else $error("wrap flag missing");
  chk_set_beats_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    (cmp_match[0]) |=> s_reg.chflag[7]) else $error("match flag lost");
  chk_irq_follows: assert property (@(posedge CLK) disable iff (!RESETN)
    (|(s_reg.chmask & s_reg.chflag)) |-> TIMER_IRQ)
    else $error("irq not raised");
  chk_prescale_locked: assert property (@(posedge CLK) disable iff (!RESETN)
    s_reg.pr_lock |=> $stable(s_reg.mask2[1:0]))
    else $error("prescale changed after lock");
  chk_ch1_pin_data: assert property (@(posedge CLK) disable iff (!RESETN)
    cmp_match[0] |=> ((PA_OUT ^ $past(s_reg.data1p[7:3])) &
                      $past(s_reg.mask1p[7:3])) == 5'h00)
    else $error("pin data not copied");
  chk_force_once: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (s_reg.force_pend != 5'h00 && s_next.step && !wr_ok)
    |=> s_reg.force_pend == 5'h00) else $error("force left pending");
  chk_rti_rose: assert property (
    @(posedge CLK) disable iff (!RESETN) $rose(s_reg.flag2[6]) |->
    ($past(s_reg.rti) & $past(rti_mask(s_reg.accctl[1:0]))) ==
    $past(rti_mask(s_reg.accctl[1:0]))) else $error("periodic flag early");
endmodule // tcr_timer_unit
`default_nettype wire
